//--- src/acc_control.sv
// control and digital post-processing of one analog comparator channel
// Functional notes
// - channel runs only while control bit 0 is set
// - control bit 18 selects window compare mode
// - control bit 17 enables the window latch
// - wake-up from power-down allowed only while bit 16 set
// - bits 15:13 filter: 000 bypass, 001..101 need 1..16 equal samples
// - filter codes 110 and 111 need 32 and 64 equal samples
// - bit 12 picks pin source: 0 unfiltered, 1 filtered
// - bits 9:8 pick edges: both, rising, falling; 11 detects nothing
// - a selected edge sets the interrupt flag
// - bits 7:6 route one of four positive input pins
// - bits 5:4 pick negative input: pin, reference, band-gap, ground
// - bit 3 inverts the comparator output
// - bit 2 requests hysteresis from the analog core
// - interrupt request raised only while bit 1 set
// - interrupt enable plus wake enable also arms the wake-up interrupt
// - control register resets to zero; bits 31:19 reserved
// - flag sticks until software writes one to it
// - result synchronised; status and output bits cleared while disabled
`timescale 1ns/1ps
module acc_control
    import acc_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // register port
    input wire acc_bus_s i_bus,
    output logic [31:0] o_rdata,
    // analog core
    input wire logic i_cmp_raw,
    output acc_ana_s o_ana,
    // pin and system outputs
    output logic o_cmp_out_pin,
    output logic o_irq,
    output logic o_wake_req
);

    acc_state_s st_reg;
    acc_state_s st_next;

    logic chan_en;
    logic cmp_val;
    logic [2:0] filt_sel;
    logic [ACC_CNT_W-1:0] filt_len;
    logic [ACC_CNT_W-1:0] cnt_inc;
    logic [1:0] pol_sel;
    logic edge_rise;
    logic edge_fall;
    logic edge_hit;
    logic [ACC_FLAG_W-1:0] flag_set;
    logic [ACC_FLAG_W-1:0] flag_clr;

    // filter length per code
    function automatic logic [ACC_CNT_W-1:0] len_of(input logic [2:0] sel);
        logic [ACC_CNT_W-1:0] len;
        len = 7'h01;
        case (sel)
            3'h1: len = 7'h01;
            3'h2: len = 7'h02;
            3'h3: len = 7'h04;
            3'h4: len = 7'h08;
            3'h5: len = 7'h10;
            3'h6: len = 7'h20;
            3'h7: len = 7'h40;
            default: len = 7'h01;
        endcase
        return len;
    endfunction : len_of

    always_comb begin
        st_next = st_reg;
        chan_en = st_reg.ctrl[ACC_EN_BIT];
        filt_sel = st_reg.ctrl[ACC_FILT_LSB +: 3];
        filt_len = len_of(filt_sel);
        cnt_inc = st_reg.cnt + 7'h01;
        pol_sel = st_reg.ctrl[ACC_POL_LSB +: 2];

        // three-stage synchroniser; change taken once stages two and three agree
        st_next.sync = {st_reg.sync[1:0], i_cmp_raw};
        if (st_reg.sync[1] == st_reg.sync[2]) begin
            st_next.stable = st_reg.sync[2];
        end
        cmp_val = st_reg.stable ^ st_reg.ctrl[ACC_INV_BIT];

        // output filter
        if (filt_sel == ACC_FILT_OFF) begin
            st_next.filt = cmp_val;
            st_next.cnt = '0;
        end else if (cmp_val == st_reg.filt) begin
            st_next.cnt = '0;
        end else if (cnt_inc >= filt_len) begin
            st_next.filt = cmp_val;
            st_next.cnt = '0;
        end else begin
            st_next.cnt = cnt_inc;
        end

        // pin source
        if (st_reg.ctrl[ACC_PIN_OUTPUT_SOURCE_SELECT_BIT]) begin
            st_next.pin = st_reg.filt;
        end else begin
            st_next.pin = cmp_val;
        end

        // edge detection on consecutive samples
        st_next.prev = st_reg.filt;
        edge_rise = st_reg.filt & ~st_reg.prev;
        edge_fall = ~st_reg.filt & st_reg.prev;
        case (pol_sel)
            ACC_POL_BOTH: edge_hit = edge_rise | edge_fall;
            ACC_POL_RISE: edge_hit = edge_rise;
            ACC_POL_FALL: edge_hit = edge_fall;
            default: edge_hit = 1'b0;
        endcase
        edge_hit = edge_hit & chan_en;

        // sticky flags, set wins over clear
        flag_set = '0;
        flag_set[ACC_ST_EDGE_BIT] = edge_hit;
        flag_set[ACC_ST_WAKE_BIT] = edge_hit & st_reg.ctrl[ACC_IE_BIT]
            & st_reg.ctrl[ACC_WAKE_BIT];
        flag_clr = '0;
        if (i_bus.wr && i_bus.addr == ACC_STAT_OFS) begin
            flag_clr[ACC_ST_EDGE_BIT] = i_bus.wdata[ACC_ST_EDGE_BIT];
            flag_clr[ACC_ST_WAKE_BIT] = i_bus.wdata[ACC_ST_WAKE_BIT];
        end
        st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;

        // register writes
        if (i_bus.wr && i_bus.addr == ACC_CTRL_OFS) begin
            st_next.ctrl = i_bus.wdata[ACC_CTRL_W-1:0];
            st_next.cnt = '0; // new filter length restarts the count
        end
        if (i_bus.wr && i_bus.addr == ACC_MASK_OFS) begin
            st_next.mask = i_bus.wdata[ACC_FLAG_W-1:0];
        end

        // register reads, data one cycle later
        st_next.rdata = '0;
        if (i_bus.rd) begin
            case (i_bus.addr)
                ACC_CTRL_OFS: begin
                    st_next.rdata[ACC_CTRL_W-1:0] = st_reg.ctrl;
                end
                ACC_STAT_OFS: begin
                    st_next.rdata[ACC_FLAG_W-1:0] = st_reg.flags;
                    st_next.rdata[ACC_ST_OUT_BIT] = st_reg.filt & chan_en;
                    st_next.rdata[ACC_ST_STAT_BIT] = cmp_val & chan_en;
                end
                ACC_MASK_OFS: begin
                    st_next.rdata[ACC_FLAG_W-1:0] = st_reg.mask;
                end
                default: begin
                    st_next.rdata = '0;
                end
            endcase
        end

        // disabled channel holds its datapath cleared
        if (!chan_en) begin
            st_next.stable = 1'b0;
            st_next.filt = 1'b0;
            st_next.prev = 1'b0;
            st_next.cnt = '0;
            st_next.pin = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st_reg.ctrl <= ACC_CTRL_RST;
            st_reg.flags <= ACC_FLAG_RST;
            st_reg.mask <= ACC_FLAG_RST;
            st_reg.sync <= '0;
            st_reg.stable <= 1'b0;
            st_reg.filt <= 1'b0;
            st_reg.prev <= 1'b0;
            st_reg.cnt <= '0;
            st_reg.rdata <= '0;
            st_reg.pin <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // analog core controls
    assign o_ana.enable = st_reg.ctrl[ACC_EN_BIT];
    assign o_ana.pos_sel = st_reg.ctrl[ACC_POS_LSB +: 2];
    assign o_ana.neg_sel = st_reg.ctrl[ACC_NEG_LSB +: 2];
    assign o_ana.hyst = st_reg.ctrl[ACC_HYS_BIT];
    assign o_ana.window_mode = st_reg.ctrl[ACC_WMODE_BIT];
    assign o_ana.window_latch = st_reg.ctrl[ACC_WLAT_BIT];

    assign o_rdata = st_reg.rdata;
    assign o_cmp_out_pin = st_reg.pin;
    // level interrupt from unmasked sticky flags
    assign o_irq = st_reg.ctrl[ACC_IE_BIT] & (|(st_reg.flags & st_reg.mask));
    assign o_wake_req = st_reg.flags[ACC_ST_WAKE_BIT] & st_reg.ctrl[ACC_WAKE_BIT];

    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    logic [ACC_CNT_W-1:0] len_m1;
    assign len_m1 = filt_len - 7'h01;
    logic ctrl_wr;
    assign ctrl_wr = i_bus.wr && (i_bus.addr == ACC_CTRL_OFS);

    a_flag_on_edge: assert property (
        edge_hit |=> st_reg.flags[ACC_ST_EDGE_BIT])
        else $error("edge did not set flag");

    a_flag_w1c: assert property (
        st_reg.flags[ACC_ST_EDGE_BIT] && !edge_hit && flag_clr[ACC_ST_EDGE_BIT]
        |=> !st_reg.flags[ACC_ST_EDGE_BIT])
        else $error("write one did not clear flag");

    a_flag_sticky: assert property (
        st_reg.flags[ACC_ST_EDGE_BIT] && !flag_clr[ACC_ST_EDGE_BIT]
        |=> st_reg.flags[ACC_ST_EDGE_BIT])
        else $error("flag dropped without clear");

    a_irq_gated: assert property (
        !st_reg.ctrl[ACC_IE_BIT] |-> !o_irq)
        else $error("irq while disabled");

    a_irq_raised: assert property (
        st_reg.ctrl[ACC_IE_BIT] && (st_reg.flags & st_reg.mask) != '0 |-> o_irq)
        else $error("irq missing");

    a_pol_reserved: assert property (
        pol_sel == 2'h3 |-> !edge_hit)
        else $error("reserved polarity detected edge");

    a_wake_cause: assert property (
        $rose(st_reg.flags[ACC_ST_WAKE_BIT])
        |-> $past(st_reg.ctrl[ACC_IE_BIT] && st_reg.ctrl[ACC_WAKE_BIT]))
        else $error("wake flag without enables");

    a_disabled_clear: assert property (
        !chan_en |=> !st_reg.filt && !o_cmp_out_pin)
        else $error("disabled channel not cleared");

    a_filter_len: assert property (
        chan_en && filt_sel != ACC_FILT_OFF && cmp_val != st_reg.filt && cnt_inc >= filt_len
        |-> st_reg.cnt == len_m1 ##1 st_reg.filt == $past(cmp_val))
        else $error("filter changed at wrong count");

    a_pin_source: assert property (
        chan_en && !st_reg.ctrl[ACC_PIN_OUTPUT_SOURCE_SELECT_BIT] |=> o_cmp_out_pin == $past(cmp_val))
        else $error("pin not from unfiltered result");

    a_ctrl_reset: assert property (
        $fell(i_rst) |-> st_reg.ctrl == ACC_CTRL_RST && !o_irq)
        else $error("control not reset");

    a_ctrl_write: assert property (
        ctrl_wr |=> st_reg.ctrl == $past(i_bus.wdata[ACC_CTRL_W-1:0]))
        else $error("control write not taken");

    a_ctrl_hold: assert property (
        !ctrl_wr |=> $stable(st_reg.ctrl))
        else $error("control changed without write");

    a_mask_write: assert property (
        i_bus.wr && i_bus.addr == ACC_MASK_OFS |=> st_reg.mask == $past(i_bus.wdata[ACC_FLAG_W-1:0]))
        else $error("mask write not taken");

    a_rdata_idle: assert property (
        !i_bus.rd |=> o_rdata == '0)
        else $error("read data without read");

    a_rdata_ctrl: assert property (
        i_bus.rd && i_bus.addr == ACC_CTRL_OFS
        |=> o_rdata[31:ACC_CTRL_W] == '0 && o_rdata[ACC_CTRL_W-1:0] == $past(st_reg.ctrl))
        else $error("control read wrong");

    a_rdata_unmapped: assert property (
        i_bus.rd && i_bus.addr != ACC_CTRL_OFS && i_bus.addr != ACC_STAT_OFS
        && i_bus.addr != ACC_MASK_OFS |=> o_rdata == '0)
        else $error("unmapped read not zero");

    a_stat_reserved: assert property (
        i_bus.rd && i_bus.addr == ACC_STAT_OFS
        |=> o_rdata[31:13] == '0 && o_rdata[11:5] == '0 && o_rdata[3:2] == '0)
        else $error("status reserved bits set");

    a_stat_dis: assert property (
        i_bus.rd && i_bus.addr == ACC_STAT_OFS && !chan_en
        |=> !o_rdata[ACC_ST_OUT_BIT] && !o_rdata[ACC_ST_STAT_BIT])
        else $error("status of disabled channel not clear");

    a_stat_flags: assert property (
        i_bus.rd && i_bus.addr == ACC_STAT_OFS |=> o_rdata[ACC_FLAG_W-1:0] == $past(st_reg.flags))
        else $error("status flags read wrong");

    a_sync_shift: assert property (
        st_reg.sync[1] == $past(st_reg.sync[0]))
        else $error("synchroniser did not shift");

    a_stable_agree: assert property (
        chan_en && st_reg.sync[1] == st_reg.sync[2] |=> st_reg.stable == $past(st_reg.sync[2]))
        else $error("agreeing stages not taken");

    a_stable_hold: assert property (
        chan_en && st_reg.sync[1] != st_reg.sync[2] |=> $stable(st_reg.stable))
        else $error("disagreeing stages taken");

    a_bypass: assert property (
        chan_en && filt_sel == ACC_FILT_OFF |=> st_reg.filt == $past(cmp_val))
        else $error("bypass filter not direct");

    a_filter_agree: assert property (
        chan_en && filt_sel != ACC_FILT_OFF && cmp_val == st_reg.filt
        |=> st_reg.cnt == '0 && $stable(st_reg.filt))
        else $error("agreeing sample did not restart");

    a_filter_count: assert property (
        chan_en && !ctrl_wr && filt_sel != ACC_FILT_OFF && cmp_val != st_reg.filt
        && cnt_inc < filt_len |=> st_reg.cnt == $past(cnt_inc) && $stable(st_reg.filt))
        else $error("filter count did not advance");

    a_count_bound: assert property (
        chan_en && filt_sel != ACC_FILT_OFF |-> st_reg.cnt < filt_len)
        else $error("filter count beyond length");

    a_pin_filtered: assert property (
        chan_en && st_reg.ctrl[ACC_PIN_OUTPUT_SOURCE_SELECT_BIT] |=> o_cmp_out_pin == $past(st_reg.filt))
        else $error("pin not from filter");

    a_edge_rise: assert property (
        pol_sel == ACC_POL_RISE && edge_hit |-> st_reg.filt && !st_reg.prev)
        else $error("rising mode took falling edge");

    a_edge_fall: assert property (
        pol_sel == ACC_POL_FALL && edge_hit |-> !st_reg.filt && st_reg.prev)
        else $error("falling mode took rising edge");

    a_pol_both: assert property (
        pol_sel == ACC_POL_BOTH && chan_en && st_reg.filt != st_reg.prev |-> edge_hit)
        else $error("both-edge mode missed edge");

    a_no_edge_dis: assert property (
        !chan_en |-> !edge_hit)
        else $error("edge on disabled channel");

    a_prev_follows: assert property (
        chan_en |=> st_reg.prev == $past(st_reg.filt))
        else $error("previous sample not kept");

    a_wake_flag_set: assert property (
        edge_hit && st_reg.ctrl[ACC_IE_BIT] && st_reg.ctrl[ACC_WAKE_BIT]
        |=> st_reg.flags[ACC_ST_WAKE_BIT])
        else $error("wake flag not set");

    a_wake_gate: assert property (
        !st_reg.ctrl[ACC_WAKE_BIT] |-> !o_wake_req)
        else $error("wake request while disabled");

    a_irq_masked: assert property (
        (st_reg.flags & st_reg.mask) == '0 |-> !o_irq)
        else $error("irq without unmasked flag");

    a_flag_clr_wake: assert property (
        st_reg.flags[ACC_ST_WAKE_BIT] && flag_clr[ACC_ST_WAKE_BIT] && !flag_set[ACC_ST_WAKE_BIT]
        |=> !st_reg.flags[ACC_ST_WAKE_BIT])
        else $error("wake flag not cleared");

    a_window_bits: assert property (
        ctrl_wr |=> o_ana.window_mode == $past(i_bus.wdata[ACC_WMODE_BIT])
        && o_ana.window_latch == $past(i_bus.wdata[ACC_WLAT_BIT]))
        else $error("window controls wrong");

    a_ana_route: assert property (
        ctrl_wr |=> o_ana.pos_sel == $past(i_bus.wdata[ACC_POS_LSB +: 2])
        && o_ana.neg_sel == $past(i_bus.wdata[ACC_NEG_LSB +: 2]))
        else $error("input routing wrong");

    a_hyst_enable: assert property (
        ctrl_wr |=> o_ana.hyst == $past(i_bus.wdata[ACC_HYS_BIT])
        && o_ana.enable == $past(i_bus.wdata[ACC_EN_BIT]))
        else $error("hysteresis or enable wrong");

    c_edge_flag: cover property (edge_hit ##1 st_reg.flags[ACC_ST_EDGE_BIT]);
    c_irq_up: cover property ($rose(o_irq));
    c_long_filter: cover property (filt_sel == 3'h7 && $changed(st_reg.filt));
    c_wake: cover property ($rose(o_wake_req));

endmodule : acc_control

//--- src/acc_pkg.sv
// constants and carrier types for the comparator channel control logic
package acc_pkg;
    // register offsets
    localparam logic [7:0] ACC_CTRL_OFS = 8'h04;
    localparam logic [7:0] ACC_STAT_OFS = 8'h08;
    localparam logic [7:0] ACC_MASK_OFS = 8'h0C;
    // control register layout
    localparam int ACC_CTRL_W = 19;
    localparam logic [ACC_CTRL_W-1:0] ACC_CTRL_RST = 19'h0_0000;
    localparam int ACC_EN_BIT = 0;
    localparam int ACC_IE_BIT = 1;
    localparam int ACC_HYS_BIT = 2;
    localparam int ACC_INV_BIT = 3;
    localparam int ACC_NEG_LSB = 4;
    localparam int ACC_POS_LSB = 6;
    localparam int ACC_POL_LSB = 8;
    localparam int ACC_PIN_OUTPUT_SOURCE_SELECT_BIT = 12;
    localparam int ACC_FILT_LSB = 13;
    localparam int ACC_WAKE_BIT = 16;
    localparam int ACC_WLAT_BIT = 17;
    localparam int ACC_WMODE_BIT = 18;
    // status register layout
    localparam int ACC_FLAG_W = 2;
    localparam logic [ACC_FLAG_W-1:0] ACC_FLAG_RST = 2'h0;
    localparam int ACC_ST_EDGE_BIT = 0;
    localparam int ACC_ST_WAKE_BIT = 1;
    localparam int ACC_ST_OUT_BIT = 4;
    localparam int ACC_ST_STAT_BIT = 12;
    // edge polarity codes
    localparam logic [1:0] ACC_POL_BOTH = 2'h0;
    localparam logic [1:0] ACC_POL_RISE = 2'h1;
    localparam logic [1:0] ACC_POL_FALL = 2'h2;
    // filter
    localparam logic [2:0] ACC_FILT_OFF = 3'h0;
    localparam int ACC_CNT_W = 7;
    localparam int ACC_SYNC_N = 3;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } acc_bus_s;

    // controls toward the analog core
    typedef struct packed {
        logic enable;
        logic [1:0] pos_sel;
        logic [1:0] neg_sel;
        logic hyst;
        logic window_mode;
        logic window_latch;
    } acc_ana_s;

    // whole state of the channel
    typedef struct packed {
        logic [ACC_CTRL_W-1:0] ctrl;
        logic [ACC_FLAG_W-1:0] flags;
        logic [ACC_FLAG_W-1:0] mask;
        logic [ACC_SYNC_N-1:0] sync;
        logic stable;
        logic filt;
        logic prev;
        logic [ACC_CNT_W-1:0] cnt;
        logic [31:0] rdata;
        logic pin;
    } acc_state_s;
endpackage : acc_pkg

//--- sim/acc_core_model.sv
// behavioural analog comparator core with input selection and hysteresis
`timescale 1ns/1ps
module acc_core_model
    import acc_pkg::*;
#(
    parameter logic [7:0] BANDGAP_LVL = 8'h80
)
(
    // clock for the idle wander
    input wire logic i_clock,
    // analog levels
    input wire logic [31:0] i_pos_lvl,
    input wire logic [7:0] i_neg_lvl,
    input wire logic [7:0] i_ref_lvl,
    // controls and result
    input wire acc_ana_s i_ana,
    output logic o_raw
);
    logic [7:0] pos;
    logic [7:0] neg;
    logic [7:0] hys;
    logic wander = 1'b0;
    always_comb begin
        pos = i_pos_lvl[8 * i_ana.pos_sel +: 8];
        case (i_ana.neg_sel)
            2'h0: neg = i_neg_lvl;
            2'h1: neg = i_ref_lvl;
            2'h2: neg = BANDGAP_LVL;
            default: neg = 8'h00;
        endcase
        hys = i_ana.hyst ? 8'h04 : 8'h00;
    end
    // a switched-off core gives no trustworthy level
    always @(posedge i_clock) wander <= ~wander;
    // inside the hysteresis band the last decision holds
    always @* begin
        if (!i_ana.enable) o_raw = wander;
        else if ({1'b0, pos} > {1'b0, neg} + {1'b0, hys}) o_raw = 1'b1;
        else if ({1'b0, pos} + {1'b0, hys} < {1'b0, neg}) o_raw = 1'b0;
    end
endmodule : acc_core_model

//--- sim/tb.sv
// self-checking bench for the comparator channel control logic
`timescale 1ns/1ps
module tb;
    import acc_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    acc_bus_s i_bus = '0;
    logic [31:0] o_rdata;
    acc_ana_s o_ana;
    logic o_cmp_out_pin, o_irq, o_wake_req, raw;
    logic [31:0] pos_lvl = 32'h0;
    logic [7:0] neg_lvl = 8'h80;
    logic [7:0] ref_lvl = 8'h0;
    logic [31:0] ctl;
    int num_errors = 0;
    int checks_done = 0;
    int seed = 13;
    int cyc = 0;
    int n;
    always #5 i_clock = ~i_clock;
    acc_control dut (.i_clock(i_clock), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
        .i_cmp_raw(raw), .o_ana(o_ana), .o_cmp_out_pin(o_cmp_out_pin), .o_irq(o_irq),
        .o_wake_req(o_wake_req));
    acc_core_model core (.i_clock(i_clock), .i_pos_lvl(pos_lvl), .i_neg_lvl(neg_lvl),
        .i_ref_lvl(ref_lvl), .i_ana(o_ana), .o_raw(raw));
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
        i_bus <= '0;
        @(posedge i_clock);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        i_bus <= '0;
        #1 chk("rdata", exp & m, o_rdata & m);
        @(posedge i_clock);
    endtask : rd_chk
    task automatic drive(input logic v, input int w);
        pos_lvl <= v ? 32'hF0F0_F0F0 : 32'h1010_1010;
        repeat (w) @(posedge i_clock);
    endtask : drive
    function automatic int flen(input int k);
        return (k == 0) ? 1 : (1 << (k - 1));
    endfunction : flen
    function automatic logic hit(input int pol, input logic rise);
        return pol == 0 || (pol == 1 && rise) || (pol == 2 && !rise);
    endfunction : hit
    function automatic logic cmpv(input logic [3:0] s);
        logic [7:0] lv;
        lv = (s[1:0] == 2'h0) ? neg_lvl : (s[1:0] == 2'h1) ? ref_lvl : {~s[0], 7'h0};
        return pos_lvl[8 * s[3:2] +: 8] > lv;
    endfunction : cmpv
    initial begin
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        #1 chk("idle outputs", 32'h0, {o_ana, o_cmp_out_pin, o_irq, o_wake_req});
        rd_chk(ACC_CTRL_OFS, 32'h0, '1);
        rd_chk(8'h10, 32'h0, '1);
        repeat (8) begin
            ctl = $random(seed);
            wr(ACC_CTRL_OFS, ctl);
            chk("ana", {ctl[0], ctl[7:4], ctl[2], ctl[18:17]}, 32'(o_ana));
            rd_chk(ACC_CTRL_OFS, {13'h0, ctl[18:0]}, '1);
        end
        for (int s = 0; s < 16; s++) begin
            pos_lvl <= $random(seed) | 32'h0101_0101;
            neg_lvl <= 8'($random(seed)) & 8'hFE;
            ref_lvl <= 8'($random(seed)) & 8'hFE;
            wr(ACC_CTRL_OFS, 32'h1 | (s << 4) | ((s & 1) << 3));
            repeat (6) @(posedge i_clock);
            rd_chk(ACC_STAT_OFS, {19'h0, cmpv(s) ^ s[0], 7'h0, cmpv(s) ^ s[0], 4'h0}, 32'h1010);
        end
        neg_lvl <= 8'h80;
        for (int k = 0; k < 8; k++) begin
            wr(ACC_CTRL_OFS, 32'h1001 | (k << 13));
            drive(1'b0, 80);
            pos_lvl <= 32'hF0F0_F0F0;
            n = 0;
            do begin
                @(posedge i_clock);
                n++;
                #1;
            end while (o_cmp_out_pin !== 1'b1 && n < 200);
            chk("filter delay", 5 + flen(k), n);
        end
        wr(ACC_CTRL_OFS, 32'hE001);
        drive(1'b0, 6);
        #1 chk("unfiltered pin", 32'h0, o_cmp_out_pin);
        wr(ACC_CTRL_OFS, 32'h7001);
        drive(1'b0, 80);
        drive(1'b1, 3);
        drive(1'b0, 12);
        #1 chk("short pulse", 32'h0, o_cmp_out_pin);
        wr(ACC_MASK_OFS, 32'h3);
        wr(ACC_STAT_OFS, 32'h3);
        for (int p = 0; p < 8; p++) begin
            wr(ACC_CTRL_OFS, 32'h1 | ((p & 4) >> 1) | ((p & 3) << 8));
            for (int e = 0; e < 2; e++) begin
                drive(e == 0, 10);
                #1 chk("irq", hit(p & 3, e == 0) & p[2], o_irq);
                rd_chk(ACC_STAT_OFS, hit(p & 3, e == 0), 32'h1);
                wr(ACC_STAT_OFS, 32'h3);
                rd_chk(ACC_STAT_OFS, 32'h0, 32'h3);
            end
        end
        for (int w = 0; w < 2; w++) begin
            wr(ACC_CTRL_OFS, 32'h103 | (w << 16));
            drive(1'b0, 10);
            wr(ACC_STAT_OFS, 32'h3);
            drive(1'b1, 10);
            #1 chk("wake", w, o_wake_req);
            rd_chk(ACC_STAT_OFS, w << 1, 32'h2);
        end
        wr(ACC_MASK_OFS, 32'h0);
        #1 chk("masked irq", 32'h0, o_irq);
        wr(ACC_CTRL_OFS, 32'h1000);
        repeat (6) @(posedge i_clock);
        rd_chk(ACC_STAT_OFS, 32'h0, 32'h1010);
        #1 chk("disabled pin", 32'h0, o_cmp_out_pin);
        conclude();
    end
endmodule : tb
